/* core/csp_follower.sv */
// Cyclic synchronous position / velocity setpoint follower with
// Avalon-MM register slave. Assumes actual position and velocity
// arrive synchronous to sys_clk_i and SYNC arrives as a one-cycle pulse.
`timescale 1ns/1ps
module csp_follower
    import csp_pkg::*;
#(
    parameter int MS_COUNT = MS_CYCLES
) (
    input  wire logic        sys_clk_i,          // 20 MHz system clock
    input  wire logic        rst_b_i,            // async reset, active low
    input  wire logic [7:0]  avs_address_i,      // byte address
    input  wire logic        avs_read_i,         // read request
    input  wire logic        avs_write_i,        // write request
    input  wire logic [31:0] avs_writedata_i,    // write data
    input  wire logic [3:0]  avs_byteenable_i,   // byte lanes
    output logic [31:0]      avs_readdata_o,     // read data
    output logic             avs_waitrequest_o,  // stall
    input  wire logic        sync_i,             // SYNC event pulse
    input  wire logic [31:0] act_pos_i,          // actual position
    input  wire logic [31:0] act_vel_i,          // actual velocity
    output logic [31:0]      demand_pos_o,       // commanded position
    output logic [31:0]      demand_vel_o,       // commanded velocity
    output logic [31:0]      demand_trq_o,       // torque offset, 0.1 %
    output logic             demand_strobe_o,    // new setpoint pulse
    output logic             qstop_active_o,     // quick-stop running
    output logic [15:0]      status_o            // status word
);
    logic [7:0]         mode, ip_per, ip_idx, qs_opt, polar;
    logic [3:0]         ctrl;
    logic signed [31:0] tgt_pos, tgt_vel, pos_min, pos_max, rng_min, rng_max;
    logic signed [31:0] fe_win, qs_dec, max_spd, pos_off, vel_off, trq_off;
    logic [15:0]        fe_tmo, fe_ms;
    logic signed [31:0] fe_act;
    logic               synced, missed, seen, ferr, limit_hit;
    logic               ms_tick, cycle_tick;
    flw_state_t         state, next_state;
    logic [31:0]        rd_word;
    logic signed [31:0] next_pos, next_vel;

    function automatic logic [31:0] be_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  be);
        for (int i = 0; i < 4; i++) begin
            if (be[i]) old[i*8 +: 8] = nw[i*8 +: 8];
        end
        return old;
    endfunction : be_merge

    function automatic logic signed [31:0] clamp(input logic signed [31:0] v,
                                                 input logic signed [31:0] lim);
        if (v > lim) return lim;
        if (v < -lim) return -lim;
        return v;
    endfunction : clamp

    // Bus decode
    wire wr_go = avs_write_i && !avs_waitrequest_o;
    wire rd_take = avs_read_i && avs_waitrequest_o && !avs_write_i;
    wire [31:0] wd = avs_writedata_i;
    wire [3:0] be = avs_byteenable_i;

    // Mode and condition decode
    // mode selection
    wire is_csp = (mode == MODE_CSP);
    wire is_csv = (mode == MODE_CSV);
    wire cyclic = is_csp || is_csv;
    wire base_ok = (ip_idx == TIME_INDEX_MS) && (ip_per != 8'h00);
    // acceptance uses no control bit 4
    wire run_ok = cyclic && ctrl[CTL_ENABLE] && base_ok;
    wire nmt_op = ctrl[CTL_NMT_OP];
    wire sync_ev = sync_i && nmt_op && cyclic;
    wire apply = synced ? sync_ev : cycle_tick;
    wire follow = (state == FLW_TRACK) && run_ok;

    wire signed [31:0] pos_sum = tgt_pos + pos_off;
    wire signed [31:0] vel_sum = is_csv ? tgt_vel + vel_off : vel_off;
    wire rng_en = rng_max > rng_min;
    wire signed [31:0] rng_span = rng_max - rng_min + 32'sd1;
    wire signed [31:0] pos_wrap = !rng_en ? pos_sum :
                                  (pos_sum > rng_max) ? pos_sum - rng_span :
                                  (pos_sum < rng_min) ? pos_sum + rng_span : pos_sum;
    // limit, position mode only in closed loop
    wire spd_lim_en = is_csv || ctrl[CTL_CLOSED];
    wire signed [31:0] vel_lim = spd_lim_en ? clamp(vel_sum, max_spd) : vel_sum;
    wire signed [31:0] fe_now = act_pos_i - demand_pos_o;
    wire signed [31:0] fe_abs = fe_now[31] ? -fe_now : fe_now;
    wire outside = is_csp && (fe_abs > fe_win);
    wire signed [31:0] dv = demand_vel_o;
    // ramp toward zero by quick-stop deceleration
    wire signed [31:0] qs_vel = (qs_opt == 8'h00) ? 32'sd0 :
                                (dv > qs_dec) ? dv - qs_dec :
                                (dv < -qs_dec) ? dv + qs_dec : 32'sd0;

    cycle_timer #(
        .MS_COUNT (MS_COUNT)
    ) u_timer (
        .sys_clk_i    (sys_clk_i),
        .rst_b_i      (rst_b_i),
        .restart_i    (sync_ev),
        .period_i     (ip_per),
        .ms_tick_o    (ms_tick),
        .cycle_tick_o (cycle_tick)
    );

    always_comb begin
        next_state = state;
        case (state)
            FLW_IDLE:  begin
                if (run_ok && !ctrl[CTL_QSTOP]) next_state = FLW_TRACK;
            end
            FLW_TRACK: begin
                if (ctrl[CTL_QSTOP]) next_state = FLW_QSTOP;
                else if (!run_ok) next_state = FLW_IDLE;
            end
            FLW_QSTOP: begin
                if (!ctrl[CTL_QSTOP] && dv == 32'sd0) next_state = FLW_IDLE;
            end
            default:   next_state = FLW_IDLE;
        endcase
    end

    always_comb begin
        next_pos = demand_pos_o;
        next_vel = demand_vel_o;
        if (follow && apply) begin
            next_pos = is_csp ? pos_wrap : demand_pos_o;
            next_vel = vel_lim;
        end else if (state == FLW_QSTOP && (ms_tick || qs_opt == 8'h00)) begin
            next_vel = qs_vel;
        end
    end

    always_comb begin
        case (avs_address_i)
            OFS_MODE:    rd_word = {24'h000000, mode};
            OFS_CTRL:    rd_word = {28'h0000000, ctrl};
            OFS_STATUS:  rd_word = {16'h0000, status_o};
            OFS_TGT_POS: rd_word = tgt_pos;
            OFS_TGT_VEL: rd_word = tgt_vel;
            OFS_POS_MIN: rd_word = pos_min;
            OFS_POS_MAX: rd_word = pos_max;
            OFS_RNG_MIN: rd_word = rng_min;
            OFS_RNG_MAX: rd_word = rng_max;
            OFS_FE_WIN:  rd_word = fe_win;
            OFS_FE_TMO:  rd_word = {16'h0000, fe_tmo};
            OFS_QS_DEC:  rd_word = qs_dec;
            OFS_QS_OPT:  rd_word = {24'h000000, qs_opt};
            OFS_MAX_SPD: rd_word = max_spd;
            OFS_IP_PER:  rd_word = {24'h000000, ip_per};
            OFS_IP_IDX:  rd_word = {24'h000000, ip_idx};
            OFS_POS_OFF: rd_word = pos_off;
            OFS_VEL_OFF: rd_word = vel_off;
            OFS_TRQ_OFF: rd_word = trq_off;
            OFS_ACT_POS: rd_word = act_pos_i;
            OFS_ACT_VEL: rd_word = act_vel_i;
            OFS_FE_ACT:  rd_word = fe_act;
            OFS_POLAR:   rd_word = {24'h000000, polar};
            default:     rd_word = 32'h00000000;
        endcase
    end

    // Avalon slave: one wait cycle per access
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o    <= 32'h00000000;
        end else begin
            avs_waitrequest_o <= !((avs_read_i || avs_write_i) && avs_waitrequest_o);
            if (rd_take) avs_readdata_o <= rd_word;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mode <= 8'h00;      ctrl <= 4'h0;       tgt_pos <= '0;     tgt_vel <= '0;
            pos_min <= RST_POS_MIN;                 pos_max <= RST_POS_MAX;
            rng_min <= '0;      rng_max <= '0;      fe_win <= '0;      fe_tmo <= 16'h0000;
            qs_dec <= '0;       qs_opt <= 8'h00;    max_spd <= RST_MAX_SPD;
            ip_per <= RST_IP_PER;                   ip_idx <= RST_IP_IDX;
            pos_off <= '0;      vel_off <= '0;      trq_off <= '0;     polar <= 8'h00;
        end else if (wr_go) begin
            case (avs_address_i)
                OFS_MODE:    mode    <= 8'(be_merge({24'h0, mode}, wd, be));
                OFS_CTRL:    ctrl    <= 4'(be_merge({28'h0, ctrl}, wd, be));
                OFS_TGT_POS: tgt_pos <= be_merge(tgt_pos, wd, be);
                OFS_TGT_VEL: tgt_vel <= be_merge(tgt_vel, wd, be);
                OFS_POS_MIN: pos_min <= be_merge(pos_min, wd, be);
                OFS_POS_MAX: pos_max <= be_merge(pos_max, wd, be);
                OFS_RNG_MIN: rng_min <= be_merge(rng_min, wd, be);
                OFS_RNG_MAX: rng_max <= be_merge(rng_max, wd, be);
                OFS_FE_WIN:  fe_win  <= be_merge(fe_win, wd, be);
                OFS_FE_TMO:  fe_tmo  <= 16'(be_merge({16'h0, fe_tmo}, wd, be));
                OFS_QS_DEC:  qs_dec  <= be_merge(qs_dec, wd, be);
                OFS_QS_OPT:  qs_opt  <= 8'(be_merge({24'h0, qs_opt}, wd, be));
                OFS_MAX_SPD: max_spd <= be_merge(max_spd, wd, be);
                OFS_IP_PER:  ip_per  <= 8'(be_merge({24'h0, ip_per}, wd, be));
                OFS_IP_IDX:  ip_idx  <= 8'(be_merge({24'h0, ip_idx}, wd, be));
                OFS_POS_OFF: pos_off <= be_merge(pos_off, wd, be);
                OFS_VEL_OFF: vel_off <= be_merge(vel_off, wd, be);
                OFS_TRQ_OFF: trq_off <= be_merge(trq_off, wd, be);
                OFS_POLAR:   polar   <= 8'(be_merge({24'h0, polar}, wd, be));
                default:     ;
            endcase
        end
    end

    // Setpoint outputs and follower state
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state           <= FLW_IDLE;
            demand_pos_o    <= '0;
            demand_vel_o    <= '0;
            demand_trq_o    <= '0;
            demand_strobe_o <= 1'b0;
            qstop_active_o  <= 1'b0;
        end else begin
            state           <= next_state;
            demand_pos_o    <= next_pos;
            demand_vel_o    <= next_vel;
            demand_trq_o    <= (follow && apply) ? trq_off : demand_trq_o;
            demand_strobe_o <= follow && apply;
            qstop_active_o  <= (next_state == FLW_QSTOP);
        end
    end

    // sync tracking, two missed cycles drop lock
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            synced <= 1'b0;
            missed <= 1'b0;
            seen   <= 1'b0;
        end else if (!nmt_op || !cyclic) begin
            synced <= 1'b0;
            missed <= 1'b0;
            seen   <= 1'b0;
        end else if (sync_ev) begin
            synced <= 1'b1;
            missed <= 1'b0;
            seen   <= 1'b1;
        end else if (cycle_tick && synced) begin
            missed <= 1'b1;
            synced <= !missed;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fe_ms  <= 16'h0000;
            ferr   <= 1'b0;
            fe_act <= '0;
        end else begin
            fe_act <= fe_now;
            if (!outside) begin
                fe_ms <= 16'h0000;
                ferr  <= 1'b0;
            end else if (ms_tick) begin
                if (fe_ms != fe_tmo) fe_ms <= fe_ms + 16'h0001;
                else ferr <= 1'b1;
            end
        end
    end

    assign limit_hit = is_csp && (($signed(demand_pos_o) < pos_min) ||
                                  ($signed(demand_pos_o) > pos_max));

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            status_o <= 16'h0000;
        end else begin
            status_o            <= 16'h0000;
            status_o[ST_SYNC]   <= synced;
            status_o[ST_LIMIT]  <= limit_hit;
            status_o[ST_FOLLOW] <= follow;
            status_o[ST_FERR]   <= is_csp && ferr;
        end
    end

    a_follow_mode: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        status_o[ST_FOLLOW] |-> $past(mode) == MODE_CSP || $past(mode) == MODE_CSV)
        else $error("follow flag outside cyclic modes");
    a_vel_direct: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (follow && apply && is_csv && !ctrl[CTL_QSTOP]) |=> demand_strobe_o
            && demand_vel_o == $past(vel_lim))
        else $error("velocity demand not taken directly");
    a_pos_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (state == FLW_TRACK && !apply) |=> $stable(demand_pos_o))
        else $error("position demand moved between cycles");
    a_sync_drop: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        !nmt_op |=> ##1 !status_o[ST_SYNC])
        else $error("sync flag set while not operational");
    a_reserved_bits: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        !status_o[10] && (!$past(is_csv) || !status_o[ST_FERR]))
        else $error("reserved status bit set");
    a_limit_flag: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (is_csp && $signed(demand_pos_o) > pos_max) |=> status_o[ST_LIMIT])
        else $error("limit flag missing");
    a_ferr_clear: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        !outside |=> !ferr && fe_ms == 16'h0000)
        else $error("following error not cleared");
    a_speed_cap: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (follow && apply && is_csv) |=> $signed(demand_vel_o) <= $past(max_spd)
            && $signed(demand_vel_o) >= -$past(max_spd))
        else $error("velocity demand above maximum");
    a_bus_answer: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        (avs_read_i && avs_waitrequest_o) |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
        else $error("bus answer not after one wait cycle");
endmodule : csp_follower

/* core/csp_pkg.sv */
// Constants for the cyclic synchronous setpoint follower.
// Assumes a 20 MHz system clock and a 32-bit Avalon-MM register bus.
package csp_pkg;
    localparam logic [7:0] MODE_CSP      = 8'h08;
    localparam logic [7:0] MODE_CSV      = 8'h09;
    localparam logic [7:0] TIME_INDEX_MS = 8'hfd;   // -3, 1 ms base
    localparam int CLK_PERIOD_NS = 50;
    localparam int TIME_BASE_NS  = 1000000;
    localparam int MS_CYCLES     = TIME_BASE_NS / CLK_PERIOD_NS;
    localparam int MS_CNT_W      = 24;
    // Register byte offsets
    localparam logic [7:0] OFS_MODE    = 8'h00;
    localparam logic [7:0] OFS_CTRL    = 8'h04;
    localparam logic [7:0] OFS_STATUS  = 8'h08;
    localparam logic [7:0] OFS_TGT_POS = 8'h0c;
    localparam logic [7:0] OFS_TGT_VEL = 8'h10;
    localparam logic [7:0] OFS_POS_MIN = 8'h14;
    localparam logic [7:0] OFS_POS_MAX = 8'h18;
    localparam logic [7:0] OFS_RNG_MIN = 8'h1c;
    localparam logic [7:0] OFS_RNG_MAX = 8'h20;
    localparam logic [7:0] OFS_FE_WIN  = 8'h24;
    localparam logic [7:0] OFS_FE_TMO  = 8'h28;
    localparam logic [7:0] OFS_QS_DEC  = 8'h2c;
    localparam logic [7:0] OFS_QS_OPT  = 8'h30;
    localparam logic [7:0] OFS_MAX_SPD = 8'h34;
    localparam logic [7:0] OFS_IP_PER  = 8'h38;
    localparam logic [7:0] OFS_IP_IDX  = 8'h3c;
    localparam logic [7:0] OFS_POS_OFF = 8'h40;
    localparam logic [7:0] OFS_VEL_OFF = 8'h44;
    localparam logic [7:0] OFS_TRQ_OFF = 8'h48;
    localparam logic [7:0] OFS_ACT_POS = 8'h4c;
    localparam logic [7:0] OFS_ACT_VEL = 8'h50;
    localparam logic [7:0] OFS_FE_ACT  = 8'h54;
    localparam logic [7:0] OFS_POLAR   = 8'h58;
    // Control register bits
    localparam int CTL_ENABLE = 0;
    localparam int CTL_CLOSED = 1;
    localparam int CTL_NMT_OP = 2;
    localparam int CTL_QSTOP  = 3;
    // Status word bits
    localparam int ST_SYNC   = 8;
    localparam int ST_LIMIT  = 11;
    localparam int ST_FOLLOW = 12;
    localparam int ST_FERR   = 13;
    // Values after reset
    localparam logic [7:0]  RST_IP_PER  = 8'h01;
    localparam logic [7:0]  RST_IP_IDX  = TIME_INDEX_MS;
    localparam logic [31:0] RST_MAX_SPD = 32'h7fffffff;
    localparam logic [31:0] RST_POS_MIN = 32'h80000000;
    localparam logic [31:0] RST_POS_MAX = 32'h7fffffff;

    typedef enum logic [1:0] {
        FLW_IDLE  = 2'b00,
        FLW_TRACK = 2'b01,
        FLW_QSTOP = 2'b10
    } flw_state_t;
endpackage : csp_pkg

/* core/cycle_timer.sv */
// Millisecond tick and cycle tick generator.
// Assumes period_i is stable between cycles; restart_i re-phases both.
`timescale 1ns/1ps
module cycle_timer
    import csp_pkg::*;
#(
    parameter int MS_COUNT = MS_CYCLES
) (
    input  wire logic       sys_clk_i,    // system clock
    input  wire logic       rst_b_i,      // async reset, active low
    input  wire logic       restart_i,    // re-phase on SYNC
    input  wire logic [7:0] period_i,     // cycle length in ms
    output logic            ms_tick_o,    // one pulse per ms
    output logic            cycle_tick_o  // one pulse per cycle
);
    logic [MS_CNT_W-1:0] ms_cnt;
    logic [7:0]          cyc_cnt;
    wire                 ms_end  = (ms_cnt == MS_CNT_W'(MS_COUNT - 1));
    wire                 cyc_end = ms_end && (cyc_cnt + 8'h01 >= period_i);

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ms_cnt       <= '0;
            cyc_cnt      <= 8'h00;
            ms_tick_o    <= 1'b0;
            cycle_tick_o <= 1'b0;
        end else if (restart_i) begin
            // Keep the ms tick when SYNC lands on a ms boundary
            ms_cnt       <= '0;
            cyc_cnt      <= 8'h00;
            ms_tick_o    <= ms_end;
            cycle_tick_o <= 1'b0;
        end else begin
            ms_cnt       <= ms_end ? '0 : ms_cnt + 1'b1;
            cyc_cnt      <= cyc_end ? 8'h00 : (ms_end ? cyc_cnt + 8'h01 : cyc_cnt);
            ms_tick_o    <= ms_end;
            cycle_tick_o <= cyc_end && (period_i != 8'h00);
        end
    end
endmodule : cycle_timer

/* dv/csp_follower_test.sv */
// Self-checking bench for the cyclic setpoint follower.
// Assumes a 1 ms base shortened to 20 clock cycles.
`timescale 1ns/1ps
module csp_follower_test;
    import csp_pkg::*;
    localparam int MSC = 20;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic        waitreq;
    logic        sync;
    logic        sync_en = 1'b0;
    logic [31:0] pos_set = 32'h0;
    logic [31:0] vel_set = 32'h33;
    logic [31:0] act_pos;
    logic [31:0] act_vel;
    logic [31:0] dpos;
    logic [31:0] dvel;
    logic [31:0] dtrq;
    logic        strobe;
    logic        qstop;
    logic [15:0] status;
    int          miscompares = 0;
    int          n_compared = 0;
    int          cycles = 0;

    csp_follower #(.MS_COUNT(MSC)) i_csp_follower (
        .sys_clk_i(clk), .rst_b_i(rst_b), .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'hf),
        .avs_readdata_o(rdat), .avs_waitrequest_o(waitreq), .sync_i(sync),
        .act_pos_i(act_pos), .act_vel_i(act_vel), .demand_pos_o(dpos),
        .demand_vel_o(dvel), .demand_trq_o(dtrq), .demand_strobe_o(strobe),
        .qstop_active_o(qstop), .status_o(status));
    fieldbus_master_model #(.SYNC_GAP(MSC)) i_fieldbus_master_model (
        .sys_clk_i(clk), .rst_b_i(rst_b), .sync_en_i(sync_en), .pos_set_i(pos_set),
        .vel_set_i(vel_set), .sync_o(sync), .act_pos_o(act_pos), .act_vel_o(act_vel));

    always #25 clk = ~clk;

    task automatic tally_and_finish;
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            tally_and_finish;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clk);
        adr  <= a;
        wdat <= d;
        wr   <= w;
        rd   <= !w;
        do @(posedge clk); while (waitreq !== 1'b0);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus

    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wreg

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(q, e);
    endtask : rd_chk

    task automatic chk_bit(input int b, input logic e);
        check({31'h0, status[b]}, {31'h0, e});
    endtask : chk_bit

    task automatic wait_strobe;
        int n;
        n = 0;
        // Skip the edge at which a just-written target may still be missed
        @(posedge clk);
        do begin
            @(posedge clk);
            n++;
        end while (strobe !== 1'b1 && n < 100);
        check({31'h0, strobe}, 32'h1);
    endtask : wait_strobe

    task automatic wait_dvel(input logic [31:0] v);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (dvel === v && n < 100);
    endtask : wait_dvel

    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        rd_chk(OFS_IP_PER, 32'h1);
        rd_chk(OFS_IP_IDX, 32'hfd);
        rd_chk(OFS_MAX_SPD, RST_MAX_SPD);
        rd_chk(OFS_POS_MAX, RST_POS_MAX);
        rd_chk(8'hfc, 32'h0);
        wreg(OFS_STATUS, 32'hffff);
        check({16'h0, status}, 32'h0);
        wreg(OFS_FE_WIN, 32'h10);
        wreg(OFS_FE_TMO, 32'h2);
        wreg(OFS_POS_OFF, 32'h10);
        wreg(OFS_TRQ_OFF, 32'h7);
        // same absolute setpoint, inside the limits, written twice
        wreg(OFS_TGT_POS, 32'h1000);
        wreg(OFS_TGT_POS, 32'h1000);
        wreg(OFS_MODE, 32'h8);
        wreg(OFS_CTRL, 32'h3);
        wait_strobe;
        pos_set <= 32'h1010;
        check(dpos, 32'h1010);
        check(dtrq, 32'h7);
        chk_bit(ST_FOLLOW, 1'b1);
        chk_bit(ST_LIMIT, 1'b0);
        wait_strobe;
        check(dpos, 32'h1010);
        pos_set <= 32'h1110;
        repeat (10) @(posedge clk);
        chk_bit(ST_FERR, 1'b0);
        repeat (80) @(posedge clk);
        chk_bit(ST_FERR, 1'b1);
        rd_chk(OFS_FE_ACT, 32'h100);
        rd_chk(OFS_ACT_POS, 32'h1110);
        pos_set <= 32'h1010;
        repeat (5) @(posedge clk);
        chk_bit(ST_FERR, 1'b0);
        wreg(OFS_POS_MAX, 32'h100);
        wait_strobe;
        repeat (2) @(posedge clk);
        chk_bit(ST_LIMIT, 1'b1);
        wreg(OFS_POS_MAX, RST_POS_MAX);
        wreg(OFS_RNG_MAX, 32'hfff);
        wait_strobe;
        check(dpos, 32'h10);
        wreg(OFS_RNG_MAX, 32'h0);
        wreg(OFS_CTRL, 32'h7);
        sync_en <= 1'b1;
        repeat (60) @(posedge clk);
        chk_bit(ST_SYNC, 1'b1);
        sync_en <= 1'b0;
        repeat (70) @(posedge clk);
        chk_bit(ST_SYNC, 1'b0);
        wreg(OFS_VEL_OFF, 32'h5);
        wreg(OFS_TGT_VEL, 32'h64);
        wreg(OFS_MODE, 32'h9);
        pos_set <= 32'h9000;
        wait_strobe;
        wait_strobe;
        check(dvel, 32'h69);
        wreg(OFS_TGT_VEL, 32'h70);
        wait_strobe;
        check(dvel, 32'h75);
        wreg(OFS_MAX_SPD, 32'h20);
        wait_strobe;
        check(dvel, 32'h20);
        repeat (100) @(posedge clk);
        chk_bit(ST_FERR, 1'b0);
        chk_bit(10, 1'b0);
        rd_chk(OFS_ACT_VEL, 32'h33);
        wreg(OFS_IP_IDX, 32'hfe);
        repeat (3) @(posedge clk);
        chk_bit(ST_FOLLOW, 1'b0);
        wreg(OFS_IP_IDX, 32'hfd);
        wreg(OFS_QS_DEC, 32'h10);
        wreg(OFS_QS_OPT, 32'h1);
        wreg(OFS_CTRL, 32'h9);
        repeat (3) @(posedge clk);
        check({31'h0, qstop}, 32'h1);
        wait_dvel(32'h20);
        check(dvel, 32'h10);
        wreg(OFS_CTRL, 32'h1);
        wreg(OFS_MODE, 32'h0);
        repeat (3) @(posedge clk);
        chk_bit(ST_FOLLOW, 1'b0);
        tally_and_finish;
    end
endmodule : csp_follower_test

/* dv/fieldbus_master_model.sv */
// Far-side model: the motion master's SYNC source and the axis feedback.
// Assumes the bench sets the reported position and velocity as levels.
`timescale 1ns/1ps
module fieldbus_master_model #(
    parameter int SYNC_GAP = 20
) (
    input  wire logic        sys_clk_i,  // system clock
    input  wire logic        rst_b_i,    // async reset, active low
    input  wire logic        sync_en_i,  // send SYNC pulses
    input  wire logic [31:0] pos_set_i,  // position the axis reports
    input  wire logic [31:0] vel_set_i,  // velocity the axis reports
    output logic             sync_o,     // SYNC event pulse
    output logic [31:0]      act_pos_o,  // actual position
    output logic [31:0]      act_vel_o   // actual velocity
);
    int gap;
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            gap    <= 0;
            sync_o <= 1'b0;
        end else begin
            gap    <= (gap == SYNC_GAP - 1) ? 0 : gap + 1;
            sync_o <= sync_en_i && (gap == 0);
        end
    end
    assign act_pos_o = pos_set_i;
    assign act_vel_o = vel_set_i;
endmodule : fieldbus_master_model
